// ==== pin_watch.sv ====
// far-side model: measures the spacing of output pin toggles
`timescale 1ns/1ps
`default_nettype none
module pin_watch
(
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        nrst,
    // watched pin and result
    input  wire logic        pin,
    output logic      [15:0] gap,
    output logic             tog
);
    logic [15:0] cnt_q;
    logic        pin_q;
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cnt_q <= 16'h0;
            pin_q <= 1'b0;
            gap   <= 16'h0;
            tog   <= 1'b0;
        end
        else
        begin
            pin_q <= pin;
            tog   <= pin != pin_q;
            cnt_q <= (pin != pin_q) ? 16'h1 : cnt_q + 16'h1;
            if (pin != pin_q)
                gap <= cnt_q;
        end
    end
endmodule : pin_watch
`default_nettype wire

// ==== testbench.sv ====
// self-checking bench for the timer pair block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import timer_pair_pkg::*;
    typedef struct packed {
        logic [7:0]  md, ff, cl, cu;
        logic [15:0] ga, gb;
        logic        li, ui;
    } row_t;
    logic        core_clk = 1'b0, nrst = 1'b0, tog, pa, pb;
    logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
    logic [31:0] wdata = 32'h0, rdata, rd_q;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, rr_q, lirq, uirq;
    logic [15:0] gap, g1, g2;
    int          miscompares, n_checks, li_n, base, ui_n, ubase;
    // gaps in core_clk cycles, every lower timer on the /8 tap
    row_t rows [7] = '{
        '{8'h01, 8'h37, 8'h05, 8'h10, 16'h28, 16'h28, 1'b1, 1'b0},
        '{8'h05, 8'h3f, 8'h05, 8'h07, 16'h38, 16'h38, 1'b1, 1'b1},
        '{8'h4d, 8'h37, 8'h04, 8'h01, 16'h820, 16'h820, 1'b0, 1'b1},
        '{8'h81, 8'h37, 8'h04, 8'h0a, 16'h20, 16'h30, 1'b1, 1'b0},
        '{8'hd1, 8'h37, 8'h0a, 8'h00, 16'h50, 16'h1a8, 1'b1, 1'b0},
        '{8'he1, 8'h37, 8'h0a, 8'h00, 16'h50, 16'h3a8, 1'b1, 1'b0},
        '{8'hf1, 8'h37, 8'h0a, 8'h00, 16'h50, 16'h7a8, 1'b1, 1'b0}};
    logic [7:0] fv [7] = '{8'h22, 8'h31, 8'h30, 8'h30, 8'h13, 8'h32, 8'h00};
    logic [7:0] dm [2] = '{8'hd1, 8'h81};
    logic [1:0] fp [7] = '{2'h0, 2'h2, 2'h0, 2'h2, 2'h3, 2'h1, 2'h2};

    timer_pair_top dut_u (.core_clk(core_clk), .nrst(nrst), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .ext_count_pin(1'b0), .pair_a_output_pin(pa), .pair_b_output_pin(pb),
        .lower_timer_irq(lirq), .upper_timer_irq(uirq));
    pin_watch watch_u (.core_clk(core_clk), .nrst(nrst), .pin(pa), .gap(gap), .tog(tog));

    always #5 core_clk = ~core_clk;
    always @(posedge core_clk)
        if (lirq[0] === 1'b1) li_n <= li_n + 1;
    always @(posedge core_clk)
        if (uirq[0] === 1'b1) ui_n <= ui_n + 1;

    task automatic results;
        if (miscompares == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : results
    task automatic tmo;
        miscompares++;
        $display("[ERR] %0t timeout", $time);
        results();
    endtask : tmo
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 64; n++)
        begin
            @(posedge core_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        if (n == 64) tmo();
    endtask : wr
    task automatic rd(input logic [7:0] a);
        int n;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 64; n++)
        begin
            @(posedge core_clk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rd_q = rdata;
        rr_q = rresp;
        if (n == 64) tmo();
    endtask : rd
    task automatic twait(output logic [15:0] g);
        int n;
        for (n = 0; n < 4000; n++)
        begin
            @(posedge core_clk);
            if (tog === 1'b1) break;
        end
        g = gap;
        if (n == 4000) tmo();
    endtask : twait

    initial
    begin
        repeat (3) @(posedge core_clk);
        chk({pa, pb, lirq, uirq}, 32'h0);
        nrst <= 1'b1;
        @(posedge core_clk);
        foreach (rows[i])
        begin
            wr(OFF_RUN, 32'h0);
            wr(OFF_MODE_A, {24'h0, rows[i].md});
            wr(OFF_FFCTRL, {24'h0, rows[i].ff});
            wr(OFF_CMPL_A, {24'h0, rows[i].cl});
            wr(OFF_CMPU_A, {24'h0, rows[i].cu});
            wr(OFF_RUN, 32'h83);
            base = li_n;
            ubase = ui_n;
            twait(g1);
            twait(g1);
            twait(g2);
            chk(g1 < g2 ? g1 : g2, rows[i].ga);
            chk(g1 + g2, rows[i].ga + rows[i].gb);
            chk(li_n != base, rows[i].li);
            chk(ui_n != ubase, rows[i].ui);
        end
        // software actions with the timers stopped
        wr(OFF_RUN, 32'h0);
        foreach (fv[i])
        begin
            wr(OFF_FFCTRL, {24'h0, fv[i]});
            @(posedge core_clk);
            chk({pa, pb}, fp[i]);
        end
        rd(OFF_CMPL_A);
        chk(rd_q, 32'h0);
        rd(OFF_FFCTRL);
        chk(rd_q[1:0], ACT_READ);
        rd(8'h30);
        chk(rr_q, RESP_SLVERR);
        rd(OFF_CMPU_A);
        chk(rd_q, 32'h0);
        // double buffer: duty 0a first, buffered 14 after the cycle end
        wr(OFF_FFCTRL, 32'h37);
        wr(OFF_CMPU_A, 32'h0);
        foreach (dm[i])
        begin
            wr(OFF_RUN, 32'h0);
            wr(OFF_DBUF, 32'h0);
            wr(OFF_MODE_A, {24'h0, dm[i]});
            wr(OFF_CMPL_A, 32'h0a);
            wr(OFF_DBUF, 32'h1);
            wr(OFF_CMPL_A, 32'h14);
            wr(OFF_RUN, 32'h83);
            twait(g1);
            twait(g1);
            twait(g2);
            chk(g2, 16'ha0);
        end
        // reset in mid-run
        nrst <= 1'b0;
        repeat (3) @(posedge core_clk);
        chk({pa, pb, lirq, uirq, awready, bvalid}, 32'h0);
        nrst <= 1'b1;
        @(posedge core_clk);
        rd(OFF_RUN);
        chk(rd_q, 32'h0);
        results();
    end
endmodule : testbench
`default_nettype wire

// ==== timer_pair_pkg.sv ====
// constants shared by the dual 8-bit timer pair block
package timer_pair_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_RUN    = 8'h00;
    localparam logic [7:0] OFF_MODE_A = 8'h04;
    localparam logic [7:0] OFF_MODE_B = 8'h08;
    localparam logic [7:0] OFF_FFCTRL = 8'h0c;
    localparam logic [7:0] OFF_DBUF   = 8'h10;
    localparam logic [7:0] OFF_CMPL_A = 8'h14;
    localparam logic [7:0] OFF_CMPU_A = 8'h18;
    localparam logic [7:0] OFF_CMPL_B = 8'h1c;
    localparam logic [7:0] OFF_CMPU_B = 8'h20;
    localparam logic [7:0] OFF_COUNT  = 8'h24;

    // ------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------
    localparam int MODE_HI      = 7;   // pair_mode_field [7:6]
    localparam int PWM_LO       = 4;   // pwm_cycle_field [5:4]
    localparam int UCLK_LO      = 2;   // upper clock select [3:2]
    localparam int LCLK_LO      = 0;   // lower clock select [1:0]
    localparam int FF_STRIDE    = 4;   // per pair in flipflop_control_reg
    localparam int FF_INV_EN    = 2;
    localparam int FF_SRC       = 3;
    localparam int PRE_RUN_BIT  = 7;
    localparam logic [7:0] RST_REG8 = 8'h00;
    localparam logic [1:0] ACT_READ = 2'b11;

    typedef enum logic [1:0] {
        MODE_8BIT    = 2'b00,
        MODE_CASCADE = 2'b01,
        MODE_PULSE   = 2'b10,
        MODE_PWM     = 2'b11
    } pair_mode_t;

    typedef enum logic [1:0] {
        ACT_INVERT = 2'b00,
        ACT_SET    = 2'b01,
        ACT_CLEAR  = 2'b10,
        ACT_NONE   = 2'b11
    } ff_action_t;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // ------------------------------------------------------------
    // prescaler taps: log2 of the division from core_clk
    // ------------------------------------------------------------
    localparam int PRE_W        = 11;
    localparam int TAP_LOG [4]  = '{3, 5, 7, 11};

endpackage : timer_pair_pkg

// ==== timer_pair_top.sv ====
// two 8-bit timer pairs with shared output flip-flops, AXI4-Lite registers
//
// Implementation choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
module timer_pair_top
    import timer_pair_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    // clock and reset
    input  wire logic              core_clk,
    input  wire logic              nrst,
    // axi4-lite write
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    // axi4-lite read
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    // external count input of pair a lower timer
    input  wire logic              ext_count_pin,
    // outputs
    output logic                   pair_a_output_pin,
    output logic                   pair_b_output_pin,
    output logic [1:0]             lower_timer_irq,
    output logic [1:0]             upper_timer_irq
);
    import timer_pair_pkg::*;

    if (ADDR_W < 8)
    begin : g_chk
        $error("ADDR_W must be at least 8");
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic            awready;
        logic            wready;
        logic            bvalid;
        logic [1:0]      bresp;
        logic            arready;
        logic            rvalid;
        logic [1:0]      rresp;
        logic [31:0]     rdata;
        logic            aw_full;
        logic            w_full;
        logic [7:0]      aw_addr;
        logic [7:0]      wbyte;
        logic            wen;
        logic [7:0]      run;
        logic [1:0][7:0] mode;
        logic [7:0]      ffcfg;
        logic [1:0]      dbuf;
        logic [1:0][7:0] cmpl;
        logic [1:0][7:0] cmpu;
        logic [1:0][7:0] dbuf_val;
        logic [1:0][7:0] lcnt;
        logic [1:0][7:0] ucnt;
        logic [1:0]      cmp_en;
        logic [1:0]      ff;
        logic [1:0]      lirq;
        logic [1:0]      uirq;
        logic [2:0]      sync;
        logic            ext_lvl;
    } state_t;

    state_t     s_q;
    state_t     s_d;
    logic [3:0] tick;
    logic       wr_go;
    logic [7:0] wa;

    timer_prescaler u_pre (
        .core_clk (core_clk),
        .nrst     (nrst),
        .run      (s_q.run[PRE_RUN_BIT]),
        .tick     (tick)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic sel_lower(input logic [1:0] sel, input logic ext,
                                       input logic [3:0] tk);
        case (sel)
            2'b00:   return ext;
            2'b01:   return tk[0];
            2'b10:   return tk[1];
            default: return tk[2];
        endcase
    endfunction : sel_lower

    function automatic logic sel_upper(input logic [1:0] sel, input logic lm,
                                       input logic [3:0] tk);
        case (sel)
            2'b00:   return lm;
            2'b01:   return tk[0];
            2'b10:   return tk[2];
            default: return tk[3];
        endcase
    endfunction : sel_upper

    // unused code 00 falls back to the 6-bit cycle
    function automatic logic [7:0] pwm_top(input logic [1:0] f);
        case (f)
            2'b10:   return 8'h7f;
            2'b11:   return 8'hff;
            default: return 8'h3f;
        endcase
    endfunction : pwm_top

    function automatic logic [31:0] rd_word(input state_t s, input logic [7:0] a,
                                            output logic ok);
        logic [7:0] ffr;
        ffr = s.ffcfg;
        ok  = 1'b1;
        // action fields read as 11; flip-flop state is not visible
        ffr[1:0] = ACT_READ;
        ffr[FF_STRIDE+1:FF_STRIDE] = ACT_READ;
        if (a == OFF_RUN)
            return {24'h000000, s.run};
        else if (a == OFF_MODE_A)
            return {24'h000000, s.mode[0]};
        else if (a == OFF_MODE_B)
            return {24'h000000, s.mode[1]};
        else if (a == OFF_FFCTRL)
            return {24'h000000, ffr};
        else if (a == OFF_DBUF)
            return {30'h0, s.dbuf};
        else if (a == OFF_CMPL_A || a == OFF_CMPU_A || a == OFF_CMPL_B || a == OFF_CMPU_B)
            return 32'h00000000;
        else if (a == OFF_COUNT)
            return {s.ucnt[1], s.lcnt[1], s.ucnt[0], s.lcnt[0]};
        ok = 1'b0;
        return 32'h00000000;
    endfunction : rd_word

    assign wr_go = s_q.aw_full && s_q.w_full && !s_q.bvalid;
    assign wa    = s_q.aw_addr;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic       ext_tick;
        logic       lt;
        logic       ut;
        logic       lm;
        logic       um;
        logic       tog;
        logic       rok;
        logic [7:0] ln;
        logic [7:0] un;
        logic [15:0] n16;
        logic [1:0] md;
        ext_tick = 1'b0;
        lt  = 1'b0;
        ut  = 1'b0;
        lm  = 1'b0;
        um  = 1'b0;
        tog = 1'b0;
        rok = 1'b0;
        ln  = 8'h00;
        un  = 8'h00;
        n16 = 16'h0000;
        md  = 2'b00;
        s_d = s_q;
        s_d.lirq = 2'b00;
        s_d.uirq = 2'b00;

        // pin input: third and second stage must agree before a level counts
        s_d.sync = {s_q.sync[1:0], ext_count_pin};
        if (s_q.sync[1] == s_q.sync[2])
        begin
            s_d.ext_lvl = s_q.sync[2];
            ext_tick    = s_q.sync[2] && !s_q.ext_lvl;
        end

        for (int p = 0; p < 2; p++)
        begin
            md  = s_q.mode[p][MODE_HI:MODE_HI-1];
            lt  = s_q.run[2*p] && sel_lower(s_q.mode[p][LCLK_LO+1:LCLK_LO],
                                            (p == 0) ? ext_tick : 1'b0, tick);
            ln  = s_q.lcnt[p] + 8'h01;
            lm  = 1'b0;
            um  = 1'b0;
            tog = 1'b0;
            case (md)
                MODE_CASCADE:
                begin
                    // upper advances only on lower overflow, own select ignored
                    if (lt)
                    begin
                        n16 = {s_q.ucnt[p], s_q.lcnt[p]} + 16'h0001;
                        if (s_q.cmp_en[p] && n16 == {s_q.cmpu[p], s_q.cmpl[p]})
                        begin
                            s_d.lcnt[p] = 8'h00;
                            s_d.ucnt[p] = 8'h00;
                            s_d.uirq[p] = 1'b1;
                            tog = s_q.ffcfg[FF_STRIDE*p+FF_INV_EN];
                        end
                        else
                        begin
                            s_d.lcnt[p] = n16[7:0];
                            s_d.ucnt[p] = n16[15:8];
                        end
                    end
                end
                MODE_PULSE:
                begin
                    s_d.ucnt[p] = 8'h00;
                    if (lt)
                    begin
                        if (ln == s_q.cmpu[p])
                        begin
                            s_d.lcnt[p] = 8'h00;
                            s_d.lirq[p] = 1'b1;
                            tog = s_q.ffcfg[FF_STRIDE*p+FF_INV_EN];
                            if (s_q.dbuf[p])
                                s_d.cmpl[p] = s_q.dbuf_val[p];
                        end
                        else
                        begin
                            s_d.lcnt[p] = ln;
                            tog = (ln == s_q.cmpl[p]) && s_q.ffcfg[FF_STRIDE*p+FF_INV_EN];
                        end
                    end
                end
                MODE_PWM:
                begin
                    if (lt)
                    begin
                        if (ln == pwm_top(s_q.mode[p][PWM_LO+1:PWM_LO]))
                        begin
                            s_d.lcnt[p] = 8'h00;
                            s_d.lirq[p] = 1'b1;
                            tog = s_q.ffcfg[FF_STRIDE*p+FF_INV_EN];
                            if (s_q.dbuf[p])
                                s_d.cmpl[p] = s_q.dbuf_val[p];
                        end
                        else
                        begin
                            s_d.lcnt[p] = ln;
                            lm  = (ln == s_q.cmpl[p]);
                            tog = lm && s_q.ffcfg[FF_STRIDE*p+FF_INV_EN];
                        end
                    end
                end
                default:
                begin
                    if (lt)
                    begin
                        if (ln == s_q.cmpl[p])
                        begin
                            s_d.lcnt[p] = 8'h00;
                            s_d.lirq[p] = 1'b1;
                            lm = 1'b1;
                        end
                        else
                            s_d.lcnt[p] = ln;
                    end
                end
            endcase

            // upper runs as a plain 8-bit timer in the 8-bit and PWM modes
            if (md == MODE_8BIT || md == MODE_PWM)
            begin
                ut = s_q.run[2*p+1] && sel_upper(s_q.mode[p][UCLK_LO+1:UCLK_LO], lm, tick);
                un = s_q.ucnt[p] + 8'h01;
                if (ut)
                begin
                    if (un == s_q.cmpu[p])
                    begin
                        s_d.ucnt[p] = 8'h00;
                        s_d.uirq[p] = 1'b1;
                        um = 1'b1;
                    end
                    else
                        s_d.ucnt[p] = un;
                end
                if (md == MODE_8BIT)
                    tog = s_q.ffcfg[FF_STRIDE*p+FF_INV_EN] &&
                          (s_q.ffcfg[FF_STRIDE*p+FF_SRC] ? um : lm);
            end

            // stopped timers are held cleared
            if (!s_q.run[2*p])
                s_d.lcnt[p] = 8'h00;
            // cascaded upper half stops and clears with the lower run bit
            if (md == MODE_CASCADE ? !s_q.run[2*p] : !s_q.run[2*p+1])
                s_d.ucnt[p] = 8'h00;
            if (tog)
                s_d.ff[p] = ~s_q.ff[p];
        end

        // bus write: software flip-flop actions override a same-cycle toggle
        if (s_q.bvalid && bready)
            s_d.bvalid = 1'b0;
        if (wr_go)
        begin
            s_d.aw_full = 1'b0;
            s_d.w_full  = 1'b0;
            s_d.bvalid  = 1'b1;
            s_d.bresp   = RESP_OKAY;
            if (wa == OFF_RUN)
            begin
                if (s_q.wen)
                    s_d.run = s_q.wbyte;
            end
            else if (wa == OFF_MODE_A || wa == OFF_MODE_B)
            begin
                if (s_q.wen)
                    s_d.mode[wa == OFF_MODE_B] = s_q.wbyte;
            end
            else if (wa == OFF_FFCTRL)
            begin
                if (s_q.wen)
                begin
                    s_d.ffcfg = s_q.wbyte;
                    for (int p = 0; p < 2; p++)
                    begin
                        case (s_q.wbyte[FF_STRIDE*p+:2])
                            ACT_INVERT: s_d.ff[p] = ~s_q.ff[p];
                            ACT_SET:    s_d.ff[p] = 1'b1;
                            ACT_CLEAR:  s_d.ff[p] = 1'b0;
                            default:    ;
                        endcase
                    end
                end
            end
            else if (wa == OFF_DBUF)
            begin
                if (s_q.wen)
                    s_d.dbuf = s_q.wbyte[1:0];
            end
            else if (wa == OFF_CMPL_A || wa == OFF_CMPL_B)
            begin
                if (s_q.wen)
                begin
                    s_d.dbuf_val[wa == OFF_CMPL_B] = s_q.wbyte;
                    if (!s_q.dbuf[wa == OFF_CMPL_B])
                        s_d.cmpl[wa == OFF_CMPL_B] = s_q.wbyte;
                    s_d.cmp_en[wa == OFF_CMPL_B] = 1'b0;
                end
            end
            else if (wa == OFF_CMPU_A || wa == OFF_CMPU_B)
            begin
                if (s_q.wen)
                begin
                    s_d.cmpu[wa == OFF_CMPU_B]   = s_q.wbyte;
                    s_d.cmp_en[wa == OFF_CMPU_B] = 1'b1;
                end
            end
            else if (wa != OFF_COUNT)
                s_d.bresp = RESP_SLVERR;
        end
        if (awvalid && s_q.awready)
        begin
            s_d.aw_full = 1'b1;
            s_d.aw_addr = awaddr[7:0];
        end
        if (wvalid && s_q.wready)
        begin
            s_d.w_full = 1'b1;
            s_d.wbyte  = wdata[7:0];
            s_d.wen    = wstrb[0];
        end

        // bus read
        if (s_q.rvalid && rready)
            s_d.rvalid = 1'b0;
        if (arvalid && s_q.arready)
        begin
            s_d.rdata  = rd_word(s_q, araddr[7:0], rok);
            s_d.rresp  = rok ? RESP_OKAY : RESP_SLVERR;
            s_d.rvalid = 1'b1;
        end
        s_d.awready = !s_d.aw_full;
        s_d.wready  = !s_d.w_full;
        s_d.arready = !s_d.rvalid;
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign awready           = s_q.awready;
    assign wready            = s_q.wready;
    assign bvalid            = s_q.bvalid;
    assign bresp             = s_q.bresp;
    assign arready           = s_q.arready;
    assign rvalid            = s_q.rvalid;
    assign rdata             = s_q.rdata;
    assign rresp             = s_q.rresp;
    assign pair_a_output_pin = s_q.ff[0];
    assign pair_b_output_pin = s_q.ff[1];
    assign lower_timer_irq   = s_q.lirq;
    assign upper_timer_irq   = s_q.uirq;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    logic ffw;
    assign ffw = wr_go && wa == OFF_FFCTRL && s_q.wen;

    a_ff_invert: assert property (ffw && s_q.wbyte[1:0] == 2'b00 |=>
        pair_a_output_pin != $past(pair_a_output_pin)) else $error("invert failed");
    a_ff_clear: assert property (ffw && s_q.wbyte[1:0] == 2'b10 |=>
        !pair_a_output_pin) else $error("clear failed");
    a_ff_set: assert property (ffw && s_q.wbyte[5:4] == 2'b01 |=>
        pair_b_output_pin) else $error("set failed");
    a_cmp_no_read: assert property (arvalid && arready && araddr[7:0] == OFF_CMPU_A
        |=> rvalid && rdata == 32'h00000000) else $error("compare value read back");
    a_cmp_suspend: assert property (wr_go && wa == OFF_CMPL_A && s_q.wen |=>
        !s_q.cmp_en[0] ##1 !upper_timer_irq[0] || $past(s_q.mode[0][7:6]) != MODE_CASCADE)
        else $error("compare not suspended");
    a_casc_no_low: assert property (lower_timer_irq[0] |->
        $past(s_q.mode[0][7:6]) != MODE_CASCADE) else $error("lower irq in cascade");
    a_casc_clear: assert property (upper_timer_irq[0] && $past(s_q.mode[0][7:6]) == MODE_CASCADE
        |-> s_q.lcnt[0] == 8'h00 && s_q.ucnt[0] == 8'h00) else $error("cascade not cleared");
    a_pwm_wrap: assert property (s_q.mode[0][7:6] == MODE_PWM && !lower_timer_irq[0]
        |-> s_q.lcnt[0] <= pwm_top(s_q.mode[0][5:4])) else $error("pwm counter past top");
    a_pwm_reload: assert property (lower_timer_irq[0] && $past(s_q.dbuf[0]) && !$past(wr_go)
        && $past(s_q.mode[0][7:6]) == MODE_PWM |-> s_q.cmpl[0] == $past(s_q.dbuf_val[0]))
        else $error("buffer not reloaded");
    a_bus_resp: assert property (wr_go |=> bvalid) else $error("no write response");

    c_cascade: cover property (upper_timer_irq[0] && $past(s_q.mode[0][7:6]) == MODE_CASCADE);
    c_pulse: cover property (s_q.mode[0][7:6] == MODE_PULSE && lower_timer_irq[0]);
    c_pwm: cover property (s_q.mode[1][7:6] == MODE_PWM && lower_timer_irq[1]);

endmodule : timer_pair_top
`default_nettype wire

// ==== timer_prescaler.sv ====
// prescaler producing one-cycle tick enables for the timer clock taps
`timescale 1ns/1ps
`default_nettype none
module timer_prescaler
    import timer_pair_pkg::*;
(
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       nrst,
    // control
    input  wire logic       run,
    // taps: /8, /32, /128, /2048
    output logic      [3:0] tick
);
    import timer_pair_pkg::*;

    typedef struct packed {
        logic [PRE_W-1:0] cnt;
    } pre_state_t;

    pre_state_t s_q;
    pre_state_t s_d;

    // stopping clears the chain so restarts have a full first period
    always_comb
    begin
        s_d = s_q;
        s_d.cnt = run ? s_q.cnt + 1'b1 : '0;
        // taps written out: a part-select bound must be constant
        tick[0] = run && (&s_q.cnt[TAP_LOG[0]-1:0]);
        tick[1] = run && (&s_q.cnt[TAP_LOG[1]-1:0]);
        tick[2] = run && (&s_q.cnt[TAP_LOG[2]-1:0]);
        tick[3] = run && (&s_q.cnt[TAP_LOG[3]-1:0]);
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            s_q <= '0;
        else
            s_q <= s_d;
    end

endmodule : timer_prescaler
`default_nettype wire
